// ==== pkg/rlt_map.vh ====
`ifndef RLT_MAP_VH
`define RLT_MAP_VH
`define RLT_ADDR_W 3
`define RLT_OFF_CTRL_UPPER 3'h0
`define RLT_OFF_CTRL_LOWER 3'h1
`define RLT_OFF_COUNT_LOWER 3'h2
`define RLT_OFF_COUNT_UPPER 3'h3
`define RLT_OFF_RELOAD_LOWER 3'h4
`define RLT_OFF_RELOAD_UPPER 3'h5
`define RLT_OFF_IRQ_STATUS 3'h6
`define RLT_OFF_IRQ_MASK 3'h7
`define RLT_CLKSEL_LSB 0
`define RLT_CLKSEL_MSB 2
`define RLT_TMODE_LSB 3
`define RLT_TMODE_MSB 5
`define RLT_CLKSEL_EVENT 3'h7
`define RLT_BIT_SOFTTRIG 0
`define RLT_BIT_RUNEN 1
`define RLT_BIT_UFLOW 2
`define RLT_BIT_IRQEN 3
`define RLT_BIT_RELOAD 4
`define RLT_BIT_OUTINV 5
`define RLT_BIT_OUTEN 6
`define RLT_BIT_RUN 7
`define RLT_CTRL_UPPER_RST 8'h00
`define RLT_CTRL_LOWER_RST 8'h00
`define RLT_RELOAD_RST 16'h0000
`define RLT_COUNT_RST 16'h0000
`define RLT_IRQ_MASK_RST 8'h00
`define RLT_PRESC_W 8
`endif

// ==== design/rlt_sync_edge.v ====
`timescale 1ns/10ps
module rlt_sync_edge (
    input wire clk,
    input wire reset,
    input wire pinIn,
    output wire level,
    output wire rise,
    output wire fall
);
    reg meta_reg;
    reg sync_reg;
    reg last_reg;
    // Only sync_reg looks at meta_reg
    always @(posedge clk) begin
        if (reset) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            last_reg <= 1'b0;
        end else begin
            meta_reg <= pinIn;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end
    assign level = sync_reg;
    assign rise = sync_reg & ~last_reg;
    assign fall = ~sync_reg & last_reg;
endmodule

// ==== design/rlt_prescaler.v ====
`timescale 1ns/10ps
`include "rlt_map.vh"
module rlt_prescaler (
    input wire clk,
    input wire reset,
    input wire [2:0] clockSelect,
    output reg tick
);
    reg [`RLT_PRESC_W-1:0] div_reg;
    wire [`RLT_PRESC_W-1:0] divNext;
    reg hit;
    assign divNext = div_reg + {{(`RLT_PRESC_W-1){1'b0}}, 1'b1};
    always @* begin
        case (clockSelect)
            3'h0: hit = 1'b1;
            3'h1: hit = (div_reg[0] == 1'b1);
            3'h2: hit = (div_reg[1:0] == 2'h3);
            3'h3: hit = (div_reg[2:0] == 3'h7);
            3'h4: hit = (div_reg[4:0] == 5'h1F);
            3'h5: hit = (div_reg[5:0] == 6'h3F);
            3'h6: hit = (div_reg[7:0] == 8'hFF);
            default: hit = 1'b0;
        endcase
    end
    // One-cycle tick per divided period; divide ratio set by clockSelect
    always @(posedge clk) begin
        if (reset) begin
            div_reg <= {`RLT_PRESC_W{1'b0}};
            tick <= 1'b0;
        end else begin
            div_reg <= divNext;
            tick <= hit;
        end
    end
endmodule

// ==== design/rlt_reload_timer.v ====
`timescale 1ns/10ps
`include "rlt_map.vh"
// Notes on behaviour
// - Any clock select value except 7 counts prescaler ticks.
// - Clock select 7 counts chosen edges on the timer input pin.
// - Software trigger with run enable set starts counting.
// - External trigger mode starts counting on the chosen input edge.
// - Gate mode counts only while the input holds the chosen level.
// - Reload mode reloads the counter on underflow and keeps counting.
// - Reload mode raises an interrupt request on every underflow.
// - One-shot mode raises an interrupt on underflow.
// - One-shot output is active while the counter runs.
// - Reload mode toggles output on underflow; pin driven only when enabled.
// - Starting the timer copies the reload value into the counter.
// - Count registers read back the live 16-bit count.
// - Count clock comes from prescaler or input pin per clock mode.
// - Underflow sets the flag; request forwarded only when enabled.
// - Run enable and soft trigger written together start at once.
module rlt_reload_timer (
    input wire clk,
    input wire reset,
    input wire [`RLT_ADDR_W-1:0] regAddr,
    input wire [7:0] regWrData,
    input wire regWrite,
    input wire regRead,
    output reg [7:0] regRdData,
    input wire timerInputPin,
    output reg timerOutputPin,
    output wire timerOutputEnableN,
    output wire underflowIrq,
    output wire irqOut
);
    // Trigger mode encodings within trigger_mode_select
    localparam [2:0] MODE_SOFT = 3'h0;
    localparam [2:0] MODE_EXT_RISE = 3'h1;
    localparam [2:0] MODE_EXT_FALL = 3'h2;
    localparam [2:0] MODE_EXT_BOTH = 3'h3;
    localparam [2:0] MODE_GATE_LOW = 3'h4;
    localparam [2:0] MODE_GATE_HIGH = 3'h5;
    // Counter states
    localparam [1:0] ST_STOP = 2'h0;
    localparam [1:0] ST_WAIT = 2'h1;
    localparam [1:0] ST_RUN = 2'h2;

    reg [7:0] ctrlUpper_reg;
    reg countRunEnable_reg;
    reg underflowFlag_reg;
    reg underflowIrqEnable_reg;
    reg reloadSelect_reg;
    reg outputLevel_reg;
    reg outputEnable_reg;
    reg [15:0] reload_reg;
    reg [15:0] count_reg;
    reg [15:0] count_next;
    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg toggle_reg;
    reg toggle_next;
    reg [7:0] irqStatus_reg;
    reg [7:0] irqMask_reg;
    reg [7:0] rdData_next;
    reg edgeValid;
    reg countTick;
    reg startEvent;

    wire [2:0] countClockSelect;
    wire [2:0] triggerModeSelect;
    wire eventMode;
    wire gateMode;
    wire pinLevel;
    wire pinRise;
    wire pinFall;
    wire prescTick;
    wire writeLower;
    wire softTrigger;
    wire runEnableNew;
    wire underflow;
    wire [7:0] ctrlLowerView;
    wire statusWrite;
    wire reloadSelectNew;
    wire outputLevelNew;
    wire flagClear;
    wire [7:0] statusClear;
    wire startSeen;
    reg pinWave_next;

    assign countClockSelect = ctrlUpper_reg[`RLT_CLKSEL_MSB:`RLT_CLKSEL_LSB];
    assign triggerModeSelect = ctrlUpper_reg[`RLT_TMODE_MSB:`RLT_TMODE_LSB];
    assign eventMode = (countClockSelect == `RLT_CLKSEL_EVENT);
    assign gateMode = ~eventMode &&
        (triggerModeSelect == MODE_GATE_LOW || triggerModeSelect == MODE_GATE_HIGH);

    rlt_sync_edge inPin (
        .clk(clk),
        .reset(reset),
        .pinIn(timerInputPin),
        .level(pinLevel),
        .rise(pinRise),
        .fall(pinFall)
    );

    rlt_prescaler presc (
        .clk(clk),
        .reset(reset),
        .clockSelect(countClockSelect),
        .tick(prescTick)
    );

    function edge_match;
        input [2:0] mode;
        input rise;
        input fall;
        begin
            case (mode)
                MODE_EXT_RISE: edge_match = rise;
                MODE_EXT_FALL: edge_match = fall;
                MODE_EXT_BOTH: edge_match = rise | fall;
                default: edge_match = 1'b0;
            endcase
        end
    endfunction

    // Write strobe decode for one register index
    function reg_hit;
        input wr;
        input [`RLT_ADDR_W-1:0] addr;
        input [`RLT_ADDR_W-1:0] target;
        begin
            reg_hit = wr && (addr == target);
        end
    endfunction

    // Sticky bit update; a hardware set wins over a clear in the same cycle
    function sticky;
        input cur;
        input set;
        input clr;
        begin
            sticky = set | (cur & ~clr);
        end
    endfunction

    assign writeLower = reg_hit(regWrite, regAddr, `RLT_OFF_CTRL_LOWER);
    assign statusWrite = reg_hit(regWrite, regAddr, `RLT_OFF_IRQ_STATUS);
    assign softTrigger = writeLower && regWrData[`RLT_BIT_SOFTTRIG];
    // Trigger and run enable written together count as enabled
    assign runEnableNew = writeLower ? regWrData[`RLT_BIT_RUNEN] : countRunEnable_reg;
    // Mode bits written in this cycle steer the pin at once; stale ones would glitch it
    assign reloadSelectNew = writeLower ? regWrData[`RLT_BIT_RELOAD] : reloadSelect_reg;
    assign outputLevelNew = writeLower ? regWrData[`RLT_BIT_OUTINV] : outputLevel_reg;
    // Flag clears by writing 0, as the control bit convention goes
    assign flagClear = writeLower && ~regWrData[`RLT_BIT_UFLOW];
    assign statusClear = statusWrite ? regWrData : 8'h00;
    assign startSeen = startEvent && runEnableNew;

    always @* begin
        edgeValid = edge_match(triggerModeSelect, pinRise, pinFall);
        // Event mode: edges on the pin are the count clock
        if (eventMode) begin
            countTick = edgeValid;
        end else if (gateMode) begin
            if (triggerModeSelect == MODE_GATE_HIGH) begin
                countTick = prescTick & pinLevel;
            end else begin
                countTick = prescTick & ~pinLevel;
            end
        end else begin
            countTick = prescTick;
        end
        startEvent = softTrigger;
        if (~eventMode && ~gateMode && edgeValid) begin
            startEvent = 1'b1;
        end
    end

    assign underflow = (state_reg == ST_RUN) && countTick && (count_reg == 16'h0000);

    always @* begin
        state_next = state_reg;
        count_next = count_reg;
        toggle_next = toggle_reg;
        if (~runEnableNew) begin
            state_next = ST_STOP;
        end else if (startEvent) begin
            count_next = reload_reg;
            state_next = ST_RUN;
            toggle_next = 1'b0;
        end else begin
            case (state_reg)
                ST_STOP: state_next = ST_WAIT;
                ST_WAIT: state_next = ST_WAIT;
                ST_RUN: begin
                    if (underflow) begin
                        toggle_next = ~toggle_reg;
                        if (reloadSelect_reg) begin
                            count_next = reload_reg;
                        end else begin
                            count_next = 16'hFFFF;
                            state_next = ST_WAIT;
                        end
                    end else if (countTick) begin
                        count_next = count_reg - 16'h0001;
                    end
                end
                default: state_next = ST_STOP;
            endcase
        end
    end

    always @(posedge clk) begin
        if (reset) begin
            state_reg <= ST_STOP;
            count_reg <= `RLT_COUNT_RST;
            toggle_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            count_reg <= count_next;
            toggle_reg <= toggle_next;
        end
    end

    // Configuration registers
    always @(posedge clk) begin
        if (reset) begin
            ctrlUpper_reg <= `RLT_CTRL_UPPER_RST;
            countRunEnable_reg <= 1'b0;
            underflowIrqEnable_reg <= 1'b0;
            reloadSelect_reg <= 1'b0;
            outputLevel_reg <= 1'b0;
            outputEnable_reg <= 1'b0;
            reload_reg <= `RLT_RELOAD_RST;
            irqMask_reg <= `RLT_IRQ_MASK_RST;
        end else if (regWrite) begin
            case (regAddr)
                `RLT_OFF_CTRL_UPPER: ctrlUpper_reg <= regWrData;
                `RLT_OFF_CTRL_LOWER: begin
                    countRunEnable_reg <= regWrData[`RLT_BIT_RUNEN];
                    underflowIrqEnable_reg <= regWrData[`RLT_BIT_IRQEN];
                    reloadSelect_reg <= regWrData[`RLT_BIT_RELOAD];
                    outputLevel_reg <= regWrData[`RLT_BIT_OUTINV];
                    outputEnable_reg <= regWrData[`RLT_BIT_OUTEN];
                end
                `RLT_OFF_RELOAD_LOWER: reload_reg[7:0] <= regWrData;
                `RLT_OFF_RELOAD_UPPER: reload_reg[15:8] <= regWrData;
                `RLT_OFF_IRQ_MASK: irqMask_reg <= regWrData;
                default: reload_reg <= reload_reg;
            endcase
        end
    end

    // Sticky status; software may clear and hardware set in one cycle
    always @(posedge clk) begin
        if (reset) begin
            underflowFlag_reg <= 1'b0;
            irqStatus_reg <= 8'h00;
        end else begin
            underflowFlag_reg <= sticky(underflowFlag_reg, underflow, flagClear);
            irqStatus_reg[0] <= sticky(irqStatus_reg[0], underflow, statusClear[0]);
            irqStatus_reg[1] <= sticky(irqStatus_reg[1], startSeen, statusClear[1]);
            irqStatus_reg[7:2] <= 6'h00;
        end
    end

    assign ctrlLowerView = {
        (state_reg == ST_RUN),
        outputEnable_reg,
        outputLevel_reg,
        reloadSelect_reg,
        underflowIrqEnable_reg,
        underflowFlag_reg,
        countRunEnable_reg,
        1'b0
    };

    // Count reads are live; no latching between bytes
    always @* begin
        case (regAddr)
            `RLT_OFF_CTRL_UPPER: rdData_next = ctrlUpper_reg;
            `RLT_OFF_CTRL_LOWER: rdData_next = ctrlLowerView;
            `RLT_OFF_COUNT_LOWER: rdData_next = count_reg[7:0];
            `RLT_OFF_COUNT_UPPER: rdData_next = count_reg[15:8];
            `RLT_OFF_RELOAD_LOWER: rdData_next = reload_reg[7:0];
            `RLT_OFF_RELOAD_UPPER: rdData_next = reload_reg[15:8];
            `RLT_OFF_IRQ_STATUS: rdData_next = irqStatus_reg;
            `RLT_OFF_IRQ_MASK: rdData_next = irqMask_reg;
            default: rdData_next = 8'h00;
        endcase
    end

    // Waveform runs even while the pin is disabled, so enabling it shows the live level
    always @* begin
        if (reloadSelectNew) begin
            pinWave_next = toggle_next ^ outputLevelNew;
        end else begin
            pinWave_next = (state_next == ST_RUN) ^ outputLevelNew;
        end
    end

    always @(posedge clk) begin
        if (reset) begin
            regRdData <= 8'h00;
            timerOutputPin <= 1'b0;
        end else begin
            regRdData <= regRead ? rdData_next : 8'h00;
            timerOutputPin <= pinWave_next;
        end
    end

    assign timerOutputEnableN = ~outputEnable_reg;
    assign underflowIrq = underflowFlag_reg & underflowIrqEnable_reg;
    assign irqOut = |(irqStatus_reg & irqMask_reg);
endmodule

// ==== bench/rlt_checker_sva.sv ====
`timescale 1ns/10ps
`include "rlt_map.vh"
module rlt_checker_sva (
    input wire clk,
    input wire reset,
    input wire [`RLT_ADDR_W-1:0] regAddr,
    input wire [7:0] regWrData,
    input wire regWrite,
    input wire regRead,
    input wire [7:0] regRdData,
    input wire timerOutputPin,
    input wire timerOutputEnableN,
    input wire underflowIrq,
    input wire irqOut
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    property p_rdz; !$past(regRead) |-> regRdData == 8'h00; endproperty
    a_rdz: assert property (p_rdz) else $error("read data not idle");
    property p_rst; $fell(reset) |-> !irqOut && !underflowIrq && timerOutputEnableN; endproperty
    a_rst: assert property (p_rst) else $error("outputs not idle after reset");
    property p_trg;
        $past(regRead) && $past(regAddr) == `RLT_OFF_CTRL_LOWER |-> !regRdData[0];
    endproperty
    a_trg: assert property (p_trg) else $error("trigger bit reads one");
    property p_oe;
        regWrite && regAddr == `RLT_OFF_CTRL_LOWER |=> timerOutputEnableN == !$past(regWrData[6]);
    endproperty
    a_oe: assert property (p_oe) else $error("output enable wrong");
    property p_underflow_irq_enable; regWrite && regAddr == 3'h1 && !regWrData[3] |=> !underflowIrq; endproperty
    a_underflow_irq_enable: assert property (p_underflow_irq_enable) else $error("request while disabled");
    property p_ufh; underflowIrq && !(regWrite && regAddr == 3'h1) |=> underflowIrq; endproperty
    a_ufh: assert property (p_ufh) else $error("flag lost");
    property p_mask; regWrite && regAddr == 3'h7 && regWrData == 8'h00 |=> !irqOut; endproperty
    a_mask: assert property (p_mask) else $error("masked irq high");
    property p_stop;
        regWrite && regAddr == 3'h1 && !regWrData[1] ##1 regRead && regAddr == 3'h1
            |=> !regRdData[7];
    endproperty
    a_stop: assert property (p_stop) else $error("runs without enable");
endmodule

// ==== bench/rlt_pulse_src.sv ====
`timescale 1ns/10ps
module rlt_pulse_src (
    input wire clk,
    input wire fire,
    input wire [3:0] nPulses,
    input wire idle,
    output wire pin,
    output wire busy
);
    reg [7:0] phase_reg = 8'h00;
    assign busy = phase_reg != 8'h00;
    // Pulses last 4 cycles, well past the input synchroniser
    assign pin = idle ^ (busy & phase_reg[2]);
    always @(posedge clk) begin
        if (fire)
            phase_reg <= {1'b0, nPulses, 3'h0};
        else if (busy)
            phase_reg <= phase_reg - 8'h01;
    end
endmodule

// ==== bench/tb_rlt_reload_timer.sv ====
`timescale 1ns/10ps
`include "rlt_map.vh"
module tb_rlt_reload_timer;
    reg clk, reset, regWrite, regRead, fire, idle;
    reg [2:0] regAddr;
    reg [7:0] regWrData, rd;
    reg [3:0] nPulses;
    reg [15:0] v;
    wire [7:0] regRdData;
    wire pin, timerOutputPin, timerOutputEnableN, underflowIrq, irqOut, busy;
    integer n_mismatch, total_checks, t;
    rlt_reload_timer uut (.clk(clk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .timerInputPin(pin),
        .timerOutputPin(timerOutputPin), .timerOutputEnableN(timerOutputEnableN),
        .underflowIrq(underflowIrq), .irqOut(irqOut));
    rlt_pulse_src src (.clk(clk), .fire(fire), .nPulses(nPulses), .idle(idle), .pin(pin),
        .busy(busy));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task tk;
        begin
            @(posedge clk);
            #1;
        end
    endtask
    task chk(input [15:0] seen, input [15:0] exp);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    task wr(input [2:0] a, input [7:0] d);
        begin
            @(posedge clk);
            regWrite <= 1'b1;
            regAddr <= a;
            regWrData <= d;
            @(posedge clk);
            regWrite <= 1'b0;
        end
    endtask
    task rdb(input [2:0] a);
        begin
            @(posedge clk);
            regRead <= 1'b1;
            regAddr <= a;
            tk;
            regRead <= 1'b0;
            rd = regRdData;
        end
    endtask
    task rd16(input [2:0] a);
        begin
            rdb(a);
            v[7:0] = rd;
            rdb(a + 3'h1);
            v[15:8] = rd;
        end
    endtask
    task halt;
        begin
            @(posedge clk);
            regWrite <= 1'b1;
            regAddr <= 3'h1;
            regWrData <= 8'h00;
            @(posedge clk);
            regWrite <= 1'b0;
            regRead <= 1'b1;
            tk;
            regRead <= 1'b0;
            chk(regRdData[7], 1'b0);
            wr(3'h6, 8'hFF);
        end
    endtask
    task pulses(input [3:0] n);
        begin
            @(posedge clk);
            fire <= 1'b1;
            nPulses <= n;
            @(posedge clk);
            fire <= 1'b0;
            repeat (n * 8 + 6) tk;
        end
    endtask
    task t_regs;
        begin
            rdb(3'h0);
            chk(rd, 8'h00);
            rdb(3'h1);
            chk(rd, 8'h00);
            rdb(3'h7);
            chk(rd, 8'h00);
            rd16(3'h2);
            chk(v, 16'h0000);
            wr(3'h4, 8'h34);
            wr(3'h5, 8'h12);
            rd16(3'h4);
            chk(v, 16'h1234);
            $display("test regs done");
        end
    endtask
    task t_reload;
        begin
            wr(3'h4, 8'h03);
            wr(3'h5, 8'h00);
            wr(3'h0, 8'h00);
            wr(3'h7, 8'h01);
            wr(3'h1, 8'h5B);
            t = 0;
            while (timerOutputPin !== 1'b1 && t < 50) begin
                tk;
                t = t + 1;
            end
            t = 0;
            while (timerOutputPin === 1'b1 && t < 50) begin
                tk;
                t = t + 1;
            end
            chk(t, 4);
            chk(timerOutputEnableN, 1'b0);
            chk(underflowIrq, 1'b1);
            chk(irqOut, 1'b1);
            halt;
            tk;
            chk(underflowIrq, 1'b0);
            chk(irqOut, 1'b0);
            $display("test reload done");
        end
    endtask
    task t_oneshot;
        begin
            wr(3'h4, 8'h08);
            wr(3'h1, 8'h4B);
            repeat (3) tk;
            chk(timerOutputPin, 1'b1);
            repeat (20) tk;
            chk(underflowIrq, 1'b1);
            rdb(3'h1);
            chk(rd & 8'h84, 8'h04);
            chk(timerOutputPin, 1'b0);
            rd16(3'h2);
            chk(v, 16'hFFFF);
            halt;
            $display("test oneshot done");
        end
    endtask
    task t_ext;
        begin
            wr(3'h4, 8'h20);
            wr(3'h0, 8'h08);
            wr(3'h1, 8'h02);
            repeat (10) tk;
            rdb(3'h1);
            chk(rd[7], 1'b0);
            pulses(4'h1);
            rdb(3'h1);
            chk(rd[7], 1'b1);
            halt;
            wr(3'h0, 8'h10);
            wr(3'h1, 8'h02);
            pulses(4'h1);
            rdb(3'h1);
            chk(rd[7], 1'b1);
            halt;
            $display("test ext done");
        end
    endtask
    task t_event;
        begin
            wr(3'h4, 8'h02);
            wr(3'h0, 8'h0F);
            wr(3'h1, 8'h0B);
            pulses(4'h2);
            chk(underflowIrq, 1'b0);
            pulses(4'h1);
            chk(underflowIrq, 1'b1);
            halt;
            $display("test event done");
        end
    endtask
    task t_gate;
        begin
            wr(3'h4, 8'h10);
            wr(3'h0, 8'h28);
            wr(3'h1, 8'h03);
            repeat (20) tk;
            rd16(3'h2);
            chk(v, 16'h0010);
            idle <= 1'b1;
            repeat (10) tk;
            rd16(3'h2);
            chk(v < 16'h0010, 1'b1);
            halt;
            wr(3'h0, 8'h20);
            wr(3'h1, 8'h03);
            repeat (10) tk;
            rd16(3'h2);
            chk(v, 16'h0010);
            idle <= 1'b0;
            repeat (10) tk;
            rd16(3'h2);
            chk(v < 16'h0010, 1'b1);
            halt;
            $display("test gate done");
        end
    endtask
    task t_presc;
        begin
            wr(3'h4, 8'h03);
            wr(3'h0, 8'h01);
            wr(3'h1, 8'h5B);
            t = 0;
            while (timerOutputPin !== 1'b1 && t < 50) begin
                tk;
                t = t + 1;
            end
            t = 0;
            while (timerOutputPin === 1'b1 && t < 50) begin
                tk;
                t = t + 1;
            end
            chk(t, 8);
            halt;
            $display("test presc done");
        end
    endtask
    task give_verdict;
        begin
            $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
            if (n_mismatch == 0 && total_checks > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    initial begin
        #200000;
        n_mismatch = n_mismatch + 1;
        give_verdict;
    end
    initial begin
        n_mismatch = 0;
        total_checks = 0;
        reset = 1'b1;
        regWrite = 1'b0;
        regRead = 1'b0;
        regAddr = 3'h0;
        regWrData = 8'h00;
        fire = 1'b0;
        nPulses = 4'h0;
        idle = 1'b0;
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        t_regs;
        t_reload;
        t_oneshot;
        t_ext;
        t_event;
        t_gate;
        t_presc;
        give_verdict;
    end
endmodule
bind rlt_reload_timer rlt_checker_sva chk_i (.clk(clk), .reset(reset), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .timerOutputPin(timerOutputPin), .timerOutputEnableN(timerOutputEnableN),
    .underflowIrq(underflowIrq), .irqOut(irqOut));
